// File: design/pin_sync.sv
// Multi-stage synchroniser for pins entering the system clock domain
module pin_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage [STAGES];

    // Only the next stage reads each stage; the last feeds logic
    always_ff @(posedge clk_i) begin
        stage[0] <= async_i;
        for (int i = 1; i < STAGES; i++) begin
            stage[i] <= stage[i-1];
        end
        if (srst_i) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= reset_val_i;
            end
        end
    end

    assign sync_o = stage[STAGES-1];
endmodule : pin_sync

// File: design/req_buffer.sv
// Small FIFO with valid/ready on both sides
module req_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] full_count = CW'(DEPTH);
    localparam logic [PW-1:0] last_slot = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;

    wire do_push = in_valid_i && in_ready_o;
    wire do_pop = out_valid_o && out_ready_i;

    assign in_ready_o = (count != full_count);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == last_slot) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == last_slot) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : req_buffer

// File: design/spi_fe_pkg.sv
// Shared constants, opcodes and request types of the serial command front end
package spi_fe_pkg;

    // Opcodes
    localparam logic [7:0] latch_set_cmd = 8'h06;
    localparam logic [7:0] latch_clear_cmd = 8'h04;
    localparam logic [7:0] status_read_cmd = 8'h05;
    localparam logic [7:0] status_write_cmd = 8'h01;
    localparam logic [7:0] mem_read_cmd = 8'h03;
    localparam logic [7:0] fast_read_cmd = 8'h0B;
    localparam logic [7:0] mem_write_cmd = 8'h02;
    localparam logic [7:0] sleep_cmd = 8'hB9;
    localparam logic [7:0] identifier_read_cmd = 8'h9F;
    localparam logic [7:0] serial_number_read_cmd = 8'hC3;

    // Status register layout
    localparam int wpen_bit = 7;
    localparam int fixed_one_bit = 6;
    localparam int bp_hi_bit = 3;
    localparam int bp_lo_bit = 2;
    localparam int write_latch_flag_bit = 1;
    localparam logic [7:0] status_reset = 8'h40;

    // Address framing
    localparam int addr_width = 17;
    localparam int addr_bytes = 3;
    localparam logic [1:0] last_addr_byte = 2'(addr_bytes - 1);
    localparam logic [2:0] last_bit = 3'h7;

    // Pin synchroniser depth
    localparam int sync_stages = 2;

    typedef enum logic [2:0] {
        req_mem_read,
        req_fast_read,
        req_mem_write,
        req_sleep,
        req_id_read,
        req_sn_read
    } req_kind_t;

    typedef struct packed {
        req_kind_t kind;
        logic [addr_width-1:0] addr;
        logic [7:0] data;
    } req_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } pins_t;

    function automatic logic is_valid_opcode(input logic [7:0] op);
        unique case (op)
            latch_set_cmd, latch_clear_cmd, status_read_cmd,
            status_write_cmd, mem_read_cmd, fast_read_cmd,
            mem_write_cmd, sleep_cmd, identifier_read_cmd,
            serial_number_read_cmd: is_valid_opcode = 1'b1;
            default: is_valid_opcode = 1'b0;
        endcase
    endfunction : is_valid_opcode

endpackage : spi_fe_pkg

// File: design/spi_memory_command_front_end.sv
// Serial slave command front end: framing, mode detect, decode, write latch
// Behaviour
// - Deselected: ignore serial input, serial output stays high impedance.
// - Each instruction starts at select; one opcode per select period.
// - Sample input on clock rise, change output on clock fall.
// - All bytes travel most significant bit first.
// - Three address bytes; upper seven bits ignored, low 17 used.
// - First complete byte after select is the opcode.
// - Unknown opcode: ignore rest of frame, output stays tristated.
// - Clock level at select picks mode 0 (low) or mode 3 (high).
// - Mode 3: first bit on first rise after the first fall.
// - Decode latch set, latch clear, status read, status write.
// - Also decode read, fast read, write, sleep, id, serial number.
// - Write latch is clear after reset; writes disabled.
// - Latch set command sets latch; status flag mirrors it.
// - Status write data byte never changes the latch flag.
// - Deselect after latch clear, status write or write clears latch.
// - Latch clear command clears latch; status read shows zero.
// - Eight-bit status register configures the device.
// - Hold low freezes clock and select; hold moves with clock low; the hold pin acts at once here, whatever the clock level.
// - Latch flag sits in status bit 1.
// - Memory and status writes refused while latch is clear.
// - Serial output driven only during a read response.
module spi_memory_command_front_end
    import spi_fe_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic req_valid_o,
    input wire logic req_ready_i,
    output req_t req_o,
    output logic write_latch_flag_o,
    output logic overrun_o
);
    typedef enum {
        st_idle,
        st_opcode,
        st_addr,
        st_dummy,
        st_write_data,
        st_status_data,
        st_read_out,
        st_done,
        st_ignore
    } fe_state_t;

    localparam pins_t pins_idle = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                    hold_n: 1'b1, wp_n: 1'b1};

    pins_t pins_s;
    fe_state_t state;
    logic sel;
    logic sck_prev;
    logic mode3;
    logic armed;
    logic [7:0] shift_in;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] opcode;
    logic [addr_width-1:0] addr;
    logic [7:0] out_sr;
    logic clear_at_end;
    logic write_latch;
    logic wpen;
    logic [1:0] bp;
    logic push;
    req_t push_req;
    logic push_ready;

    pin_sync #(
        .WIDTH($bits(pins_t)),
        .STAGES(sync_stages)
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i({cs_n_i, sck_i, si_i, hold_n_i, wp_n_i}),
        .reset_val_i(pins_idle),
        .sync_o(pins_s)
    );

    // Hold low freezes both select and clock edge detection
    wire hold_ok = pins_s.hold_n;
    wire sel_fall = hold_ok && !pins_s.cs_n && !sel;
    wire sel_rise = hold_ok && pins_s.cs_n && sel;
    wire active = sel && !sel_rise && !sel_fall;
    wire sck_up = hold_ok && active && pins_s.sck && !sck_prev;
    wire sck_down = hold_ok && active && !pins_s.sck && sck_prev;
    wire bit_take = sck_up && armed;
    wire [7:0] next_shift = {shift_in[6:0], pins_s.si};
    wire byte_done = bit_take && (bit_cnt == last_bit);
    wire [addr_width-1:0] next_addr = {addr[addr_width-2:0], pins_s.si};
    wire status_locked = wpen && !pins_s.wp_n;

    // Status image: fixed bits, protection fields and latch flag
    wire [7:0] status_img =
        {wpen, 1'b1, 2'b00, bp, write_latch, 1'b0};

    assign write_latch_flag_o = write_latch;

    function automatic req_kind_t kind_of(input logic [7:0] op);
        unique case (op)
            fast_read_cmd: kind_of = req_fast_read;
            mem_write_cmd: kind_of = req_mem_write;
            sleep_cmd: kind_of = req_sleep;
            identifier_read_cmd: kind_of = req_id_read;
            serial_number_read_cmd: kind_of = req_sn_read;
            default: kind_of = req_mem_read;
        endcase
    endfunction : kind_of

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sel <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= pins_s.sck;
            if (hold_ok) begin
                sel <= !pins_s.cs_n;
            end
        end
    end

    // Frame sequencer
    always_ff @(posedge clk_i) begin
        push <= 1'b0;
        if (srst_i) begin
            state <= st_idle;
            mode3 <= 1'b0;
            armed <= 1'b0;
            shift_in <= '0;
            bit_cnt <= '0;
            byte_idx <= '0;
            opcode <= '0;
            addr <= '0;
            out_sr <= '0;
            clear_at_end <= 1'b0;
            write_latch <= 1'b0;
            wpen <= status_reset[wpen_bit];
            bp <= status_reset[bp_hi_bit:bp_lo_bit];
            push <= 1'b0;
            push_req <= '0;
        end else if (sel_fall) begin
            state <= st_opcode;
            mode3 <= pins_s.sck;
            armed <= !pins_s.sck;
            bit_cnt <= '0;
            byte_idx <= '0;
            clear_at_end <= 1'b0;
        end else if (sel_rise || !sel) begin
            state <= st_idle;
            bit_cnt <= '0;
            byte_idx <= '0;
            clear_at_end <= 1'b0;
            if (sel_rise && clear_at_end) begin
                write_latch <= 1'b0;
            end
        end else begin
            if (sck_down && mode3) begin
                armed <= 1'b1;
            end
            if (sck_down && state == st_read_out) begin
                out_sr <= {out_sr[6:0], out_sr[7]};
            end
            if (bit_take) begin
                shift_in <= next_shift;
                bit_cnt <= bit_cnt + 1'b1;
            end
            if (bit_take && state == st_addr) begin
                addr <= next_addr;
            end
            if (byte_done) begin
                unique case (state)
                    st_opcode: begin
                        opcode <= next_shift;
                        if (!is_valid_opcode(next_shift)) begin
                            state <= st_ignore;
                        end else begin
                            unique case (next_shift)
                                latch_set_cmd: begin
                                    write_latch <= 1'b1;
                                    state <= st_done;
                                end
                                latch_clear_cmd: begin
                                    clear_at_end <= 1'b1;
                                    state <= st_done;
                                end
                                status_read_cmd: begin
                                    out_sr <= status_img;
                                    state <= st_read_out;
                                end
                                status_write_cmd: begin
                                    clear_at_end <= 1'b1;
                                    state <= st_status_data;
                                end
                                mem_read_cmd, fast_read_cmd: begin
                                    state <= st_addr;
                                end
                                mem_write_cmd: begin
                                    clear_at_end <= 1'b1;
                                    state <= st_addr;
                                end
                                default: begin
                                    push_req <= '{kind: kind_of(next_shift),
                                                  addr: '0, data: '0};
                                    push <= 1'b1;
                                    state <= st_done;
                                end
                            endcase
                        end
                    end
                    st_addr: begin
                        byte_idx <= byte_idx + 1'b1;
                        if (byte_idx == last_addr_byte) begin
                            if (opcode == mem_write_cmd) begin
                                state <= st_write_data;
                            end else if (opcode == fast_read_cmd) begin
                                state <= st_dummy;
                            end else begin
                                push_req <= '{kind: req_mem_read,
                                              addr: next_addr, data: '0};
                                push <= 1'b1;
                                state <= st_done;
                            end
                        end
                    end
                    st_dummy: begin
                        push_req <= '{kind: req_fast_read, addr: addr,
                                      data: '0};
                        push <= 1'b1;
                        state <= st_done;
                    end
                    st_write_data: begin
                        // Writes pass only with the latch set
                        if (write_latch) begin
                            push_req <= '{kind: req_mem_write, addr: addr,
                                          data: next_shift};
                            push <= 1'b1;
                            addr <= addr + 1'b1;
                        end
                    end
                    st_status_data: begin
                        // Latch flag is never taken from the data byte
                        if (write_latch && !status_locked) begin
                            wpen <= next_shift[wpen_bit];
                            bp <= next_shift[bp_hi_bit:bp_lo_bit];
                        end
                        state <= st_done;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // Response shifter: the status byte repeats while the master clocks
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
        end else begin
            // Driven only while selected, not held, in a read response
            so_oe_n_o <= !(state == st_read_out && active && hold_ok);
            if (state == st_read_out && sck_down) begin
                so_o <= out_sr[7];
            end
        end
    end

    // A stalled consumer cannot pause the master, so overflow is flagged
    always_ff @(posedge clk_i) begin
        if (srst_i || sel_fall) begin
            overrun_o <= 1'b0;
        end else if (push && !push_ready) begin
            overrun_o <= 1'b1;
        end
    end

    req_buffer #(
        .WIDTH($bits(req_t)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(push),
        .in_ready_o(push_ready),
        .in_data_i(push_req),
        .out_valid_o(req_valid_o),
        .out_ready_i(req_ready_i),
        .out_data_o(req_o)
    );
endmodule : spi_memory_command_front_end

// File: verification/spi_fe_asserts.sv
// Port checker for the serial command front end
module spi_fe_asserts
    import spi_fe_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic req_valid_o,
    input wire logic write_latch_flag_o,
    input wire logic overrun_o
);
    logic [2:0] hi_cnt;
    logic [2:0] next_hi_cnt;
    // Saturating count of clocks the raw select pin has been high
    assign next_hi_cnt = !cs_n_i ? 3'h0 :
        (hi_cnt == 3'h7 ? hi_cnt : hi_cnt + 3'h1);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hi_cnt <= 3'h7;
        end else begin
            hi_cnt <= next_hi_cnt;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    reset_idle_a: assert property ($fell(srst_i) |-> so_oe_n_o
        && !write_latch_flag_o && !req_valid_o && !overrun_o)
        else $error("outputs not idle after reset");
    deselect_ignore_a: assert property (hi_cnt == 3'h7 |-> so_oe_n_o
        && $stable(write_latch_flag_o) && !$rose(req_valid_o))
        else $error("activity while deselected");
    drive_start_a: assert property ($fell(so_oe_n_o) |-> hi_cnt == 3'h0)
        else $error("output driven without select");
    out_on_fall_a: assert property (!so_oe_n_o && $past(!so_oe_n_o)
        && $changed(so_o) |-> !sck_i)
        else $error("output changed while clock high");
    latch_set_a: assert property ($rose(write_latch_flag_o) |-> hi_cnt == 3'h0)
        else $error("latch set outside a frame");
    latch_clear_a: assert property ($fell(write_latch_flag_o)
        |-> hi_cnt inside {[3'h1:3'h6]})
        else $error("latch cleared away from deselect");
    req_in_frame_a: assert property ($rose(req_valid_o) |-> hi_cnt < 3'h3)
        else $error("request raised outside a frame");
    overrun_clear_a: assert property ($fell(overrun_o) |-> hi_cnt == 3'h0)
        else $error("overrun cleared without select");
    cover property ($rose(write_latch_flag_o));
    cover property ($fell(so_oe_n_o));
    cover property ($rose(overrun_o));
endmodule : spi_fe_asserts

bind spi_memory_command_front_end spi_fe_asserts #(.BUF_DEPTH(BUF_DEPTH))
    i_spi_fe_asserts (.clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
    .req_valid_o(req_valid_o), .write_latch_flag_o(write_latch_flag_o),
    .overrun_o(overrun_o));

// File: verification/spi_master_model.sv
// Serial bus master model for modes 0 and 3
module spi_master_model (
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // One frame; rx holds the last byte seen on the output, 0 if tristated
    task automatic xfer(input logic mode3, input logic [7:0] tx[$],
                        output logic [7:0] rx);
        rx = 8'h00;
        #7.3;
        sck_o = mode3;
        #32;
        cs_n_o = 1'b0;
        #32;
        foreach (tx[i]) begin
            for (int b = 7; b >= 0; b--) begin
                sck_o = 1'b0;
                si_o = tx[i][b];
                #32;
                sck_o = 1'b1;
                rx = {rx[6:0], so_oe_n_i ? 1'b0 : so_i};
                #32;
            end
        end
        if (!mode3) begin
            sck_o = 1'b0;
            #32;
        end
        cs_n_o = 1'b1;
        // Released data line must not keep its last level
        si_o = ~si_o;
        #32;
    endtask : xfer
endmodule : spi_master_model

// File: verification/spi_memory_command_front_end_test.sv
// Self-checking bench for the serial command front end
module spi_memory_command_front_end_test;
    timeunit 1ns;
    timeprecision 100ps;
    import spi_fe_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic hold_n_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic req_ready_i = 1'b0;
    logic cs_n;
    logic sck;
    logic si;
    logic so_o;
    logic so_oe_n_o;
    logic req_valid_o;
    req_t req_o;
    logic write_latch_flag_o;
    logic overrun_o;
    logic stall = 1'b0;
    logic [31:0] seed = 32'h0000_0f21;
    int errors = 0;
    int checks = 0;
    req_t exp_q[$];

    spi_memory_command_front_end #(.BUF_DEPTH(2))
        i_spi_memory_command_front_end (.clk_i(clk_i), .srst_i(srst_i),
        .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .hold_n_i(hold_n_i),
        .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
        .req_valid_o(req_valid_o), .req_ready_i(req_ready_i),
        .req_o(req_o), .write_latch_flag_o(write_latch_flag_o),
        .overrun_o(overrun_o));
    spi_master_model i_spi_master_model (.cs_n_o(cs_n), .sck_o(sck),
        .si_o(si), .so_i(so_o), .so_oe_n_i(so_oe_n_o));

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic check_bit(input logic got, input logic exp, input string w);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s is %b, expected %b", $time, w, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: status %h, expected %h", $time, got, exp);
        end
    endtask : check_byte

    // Address matters only for memory requests, data only for writes
    task automatic compare_req(input req_t got, input req_t exp);
        checks++;
        if (got.kind !== exp.kind || (got.addr !== exp.addr && exp.kind
            inside {req_mem_read, req_fast_read, req_mem_write}) ||
            (exp.kind == req_mem_write && got.data !== exp.data)) begin
            errors++;
            $display("Error at %0t: request %h, expected %h", $time, got, exp);
        end
    endtask : compare_req

    task automatic send(input logic mode3, input logic [7:0] op);
        logic [7:0] rx;
        i_spi_master_model.xfer(mode3, {op}, rx);
    endtask : send

    task automatic status_is(input logic mode3, input logic [7:0] exp);
        logic [7:0] rx;
        i_spi_master_model.xfer(mode3, {status_read_cmd, 8'h00}, rx);
        check_byte(rx, exp);
    endtask : status_is

    task automatic drain;
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk_i);
        check_bit(exp_q.size() == 0, 1'b1, "requests delivered");
    endtask : drain

    always #2.5 clk_i = ~clk_i;

    // Consumer stalls at random
    always @(posedge clk_i) begin
        seed <= lfsr(seed);
        req_ready_i <= !stall && seed[4];
    end

    always @(posedge clk_i) begin
        if (!srst_i && req_valid_o === 1'b1 && req_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                checks++;
                errors++;
                $display("Error at %0t: unexpected request", $time);
            end else
                compare_req(req_o, exp_q.pop_front());
        end
    end

    initial begin
        #300us;
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        logic [7:0] rx;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] bad[3] = '{8'h00, 8'h07, 8'hFF};
        logic [7:0] ops[5] = '{mem_read_cmd, fast_read_cmd, sleep_cmd,
            identifier_read_cmd, serial_number_read_cmd};
        req_kind_t kinds[5] = '{req_mem_read, req_fast_read, req_sleep,
            req_id_read, req_sn_read};
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        status_is(1'b0, 8'h40);
        send(1'b1, latch_set_cmd);
        check_bit(write_latch_flag_o, 1'b1, "latch");
        status_is(1'b1, 8'h42);
        send(1'b0, latch_clear_cmd);
        check_bit(write_latch_flag_o, 1'b0, "latch");
        status_is(1'b0, 8'h40);
        i_spi_master_model.xfer(1'b0, {mem_write_cmd, 8'h00, 8'h00, 8'h10,
            8'h5A}, rx);
        foreach (bad[i]) begin
            i_spi_master_model.xfer(bad[i][0], {bad[i], latch_set_cmd,
                status_read_cmd, 8'h00}, rx);
            check_byte(rx, 8'h00);
            check_bit(write_latch_flag_o, 1'b0, "latch");
        end
        send(1'b1, latch_set_cmd);
        d0 = seed[7:0];
        d1 = seed[15:8];
        exp_q.push_back('{req_mem_write, 17'h1_FFFF, d0});
        exp_q.push_back('{req_mem_write, 17'h0_0000, d1});
        i_spi_master_model.xfer(1'b1, {mem_write_cmd, 8'hFF, 8'hFF, 8'hFF,
            d0, d1}, rx);
        check_bit(write_latch_flag_o, 1'b0, "latch");
        foreach (ops[i]) begin
            exp_q.push_back('{kinds[i], 17'h0_2345, 8'h00});
            i_spi_master_model.xfer(i[0], {ops[i], 8'h00, 8'h23, 8'h45,
                8'hA5}, rx);
        end
        drain();
        send(1'b0, latch_set_cmd);
        i_spi_master_model.xfer(1'b0, {status_write_cmd, 8'h8F}, rx);
        check_bit(write_latch_flag_o, 1'b0, "latch");
        status_is(1'b1, 8'hCC);
        i_spi_master_model.xfer(1'b0, {status_write_cmd, 8'h00}, rx);
        status_is(1'b0, 8'hCC);
        // Protection pin low with the enable bit set blocks status writes
        @(posedge clk_i) wp_n_i <= 1'b0;
        send(1'b0, latch_set_cmd);
        i_spi_master_model.xfer(1'b0, {status_write_cmd, 8'h00}, rx);
        status_is(1'b0, 8'hCC);
        @(posedge clk_i) begin
            wp_n_i <= 1'b1;
            hold_n_i <= 1'b0;
        end
        send(1'b0, latch_set_cmd);
        check_bit(write_latch_flag_o, 1'b0, "latch");
        @(posedge clk_i) hold_n_i <= 1'b1;
        stall <= 1'b1;
        repeat (2) begin
            exp_q.push_back('{req_sleep, 17'h0_0000, 8'h00});
            send(1'b0, sleep_cmd);
        end
        send(1'b1, sleep_cmd);
        check_bit(overrun_o, 1'b1, "overrun");
        stall <= 1'b0;
        drain();
        status_is(1'b0, 8'hCC);
        check_bit(overrun_o, 1'b0, "overrun");
        close_out();
    end
endmodule : spi_memory_command_front_end_test
